// ### logic/dio_regs_pkg.sv
// Register map, field positions, reset values and tick counts shared by
// the control block and its input glitch filter.
// Assumes a 100 MHz core clock and word-addressed Avalon-MM access.
package dio_regs_pkg;

    // ------------------------------------------------------------
    // Clock and tick timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;      // Core clock period
    localparam int WDT_TICK_NS = 100;       // Watchdog count weight
    localparam int FILT_TICK_NS = 200;      // Glitch window count weight
    localparam int WDT_TICK_CYCLES = (WDT_TICK_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int FILT_TICK_CYCLES = (FILT_TICK_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_STROBES = 8'h01;      // Write-only strobes
    localparam logic [7:0] IDX_EVENTS = 8'h02;       // Event status
    localparam logic [7:0] IDX_INT_ENABLE = 8'h03;   // Interrupt enables
    localparam logic [7:0] IDX_DEVICE_VERSION = 8'h04;
    localparam logic [7:0] IDX_GLITCH_WINDOW = 8'h08;
    localparam logic [7:0] IDX_CLOCK_SOURCE_SELECT = 8'h14;
    localparam logic [7:0] IDX_WDT_ACTION_ENABLE = 8'h15;
    localparam logic [7:0] IDX_WDT_EXPIRED_STATUS = 8'h17;
    localparam logic [7:0] IDX_WATCHDOG_TIMEOUT_INTERVAL = 8'h18;
    localparam logic [7:0] IDX_OUTPUT_NORMAL = 8'h1c;
    localparam logic [7:0] IDX_OUTPUT_EXPIRE = 8'h1d;
    localparam logic [7:0] IDX_INPUT_STATE = 8'h1e;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int GLITCH_W = 20;           // Glitch window field width
    localparam int STB_EXPIRY_CLEAR = 4;    // Strobe register bits
    localparam int STB_RESTART = 5;
    localparam int STB_EVENT_CLEAR = 6;
    localparam int EVT_WDT = 5;             // Event status bit
    localparam int EVT_MASTER = 2;
    localparam int IE_WDT = 5;              // Interrupt enable bits
    localparam int IE_MASTER = 2;
    localparam int CLK_AUTO_OFF = 0;        // Clock select byte bits
    localparam int CLK_SOURCE = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_GLITCH_WINDOW = 32'h0000_0000;
    localparam logic [31:0] RST_WDT_TIMEOUT = 32'h0000_0000;
    localparam logic [7:0] RST_BYTE = 8'h00;

endpackage

// ### logic/input_glitch_filter.sv
// Per-line glitch filter: a line change is passed on only after the raw
// level has held steady for the programmed window of 200 ns counts.
// Assumes raw inputs are already synchronous to core_clk.
`timescale 1ns/1ps
module input_glitch_filter
    import dio_regs_pkg::*;
#(
    parameter int IN_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [IN_W-1:0] raw_in,
    input wire logic [GLITCH_W-1:0] window_count,
    output logic [IN_W-1:0] filtered_out
);

    // ------------------------------------------------------------
    // Shared 200 ns tick
    // ------------------------------------------------------------
    localparam logic [7:0] TICK_LAST = 8'(FILT_TICK_CYCLES - 1);

    logic [7:0] tick_cnt_reg;   // Cycles within one filter tick
    logic tick_reg;             // One-cycle pulse every 200 ns

    // Free-running prescaler; one tick shared by all lines saves area
    // at the cost of up to one tick of jitter on the window start
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TICK_LAST) begin
            tick_cnt_reg <= 8'h00;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 8'h01;
            tick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Per-line stability counters
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < IN_W; i++) begin : g_line
            logic [GLITCH_W-1:0] held_reg;  // Ticks the new level held

            // A change shorter than the window less one tick never reaches the output
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    held_reg <= '0;
                    filtered_out[i] <= 1'b0;
                end else if (raw_in[i] == filtered_out[i]) begin
                    held_reg <= '0;                 // Glitch ended, restart
                end else if (held_reg >= window_count) begin
                    filtered_out[i] <= raw_in[i];
                    held_reg <= '0;
                end else if (tick_reg) begin
                    held_reg <= held_reg + 1'b1;
                end
            end
        end
    endgenerate

endmodule

// ### logic/dio_watchdog_filter_clock_regs.sv
// Control and status registers of a static digital I/O board: version word,
// glitch window, system clock source choice and the watchdog timer.
// Assumes an Avalon-MM master with word addresses and synchronous inputs.
//
// Summary of operation
// - Read-only 32-bit version word always readable
// - Programmable window rejects short input glitches
// - Window is 20 low bits, 200 ns each
// - Clock choice disable bit resets to zero
// - Disable bit set forces onboard oscillator
// - Status bit: 0 backplane, 1 onboard clock
// - Enabled expiry drives outputs to expiry states
// - Expired status reads zero in normal operation
// - Expired status reads one once expired
// - Wait programmed 32-bit count of 100 ns
// - Expiry clear leaves expiry state, undoes effects
// - Expiry sets flag; interrupt needs both enables
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
module dio_watchdog_filter_clock_regs
    import dio_regs_pkg::*;
#(
    parameter int OUT_W = 8,
    parameter int IN_W = 8,
    parameter logic [31:0] VERSION_WORD = 32'h0001_0000 // Arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic backplane_clk_present,
    input wire logic [IN_W-1:0] raw_in,
    output logic [IN_W-1:0] filtered_in,
    output logic [OUT_W-1:0] data_out,
    output logic clk_source_onboard,
    output logic watchdog_expired_flag,
    output logic irq
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [GLITCH_W-1:0] glitch_window_count;   // Filter window in ticks
    logic auto_clock_choice_off;                 // Manual clock choice
    logic system_clock_source_flag;              // Active clock source
    logic watchdog_expire_action_enable;         // Expiry drives outputs
    logic [31:0] watchdog_timeout_count;         // Timeout in 100 ns units
    logic [OUT_W-1:0] output_normal_reg;         // Outputs when healthy
    logic [OUT_W-1:0] output_expire_reg;         // Outputs when expired
    logic watchdog_event_flag;                   // Sticky expiry event
    logic wdt_int_enable_reg;                    // Watchdog interrupt enable
    logic master_int_enable_reg;                 // Global interrupt enable
    logic [31:0] wdt_ticks_reg;                  // Ticks since restart
    logic [3:0] wdt_pre_reg;                     // Cycles within a tick
    logic [31:0] read_next;                      // Read mux output

    // ------------------------------------------------------------
    // Bus handshake decode
    // ------------------------------------------------------------
    // A write is accepted on the edge where waitrequest is seen low; a read is captured one edge earlier, while it is high
    logic wr_go;
    logic rd_start;
    logic strobe_restart;
    logic strobe_expiry_clear;
    logic strobe_event_clear;
    logic wdt_tick;
    logic wdt_hit;

    assign wr_go = avs_write && !avs_waitrequest;
    assign rd_start = avs_read && avs_waitrequest;
    assign strobe_restart = wr_go && (avs_address == IDX_STROBES)
                            && avs_byteenable[0]
                            && avs_writedata[STB_RESTART];
    assign strobe_expiry_clear = wr_go && (avs_address == IDX_STROBES)
                                 && avs_byteenable[0]
                                 && avs_writedata[STB_EXPIRY_CLEAR];
    assign strobe_event_clear = wr_go && (avs_address == IDX_STROBES)
                                && avs_byteenable[0]
                                && avs_writedata[STB_EVENT_CLEAR];

    // ------------------------------------------------------------
    // Avalon-MM handshake
    // ------------------------------------------------------------
    // One wait state on every access: waitrequest drops for exactly one
    // cycle after a request is seen, then rises again for the next one
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Read mux; unmapped indices and reserved bits read as zero
    always_comb begin
        read_next = 32'h0000_0000;
        case (avs_address)
            IDX_DEVICE_VERSION: begin
                read_next = VERSION_WORD;
            end
            IDX_GLITCH_WINDOW: begin
                read_next[GLITCH_W-1:0] = glitch_window_count;
            end
            IDX_CLOCK_SOURCE_SELECT: begin
                // Bit 0 is write-only and reads as zero
                read_next[CLK_SOURCE] = system_clock_source_flag;
            end
            IDX_WDT_ACTION_ENABLE: begin
                read_next[0] = watchdog_expire_action_enable;
            end
            IDX_WDT_EXPIRED_STATUS: begin
                read_next[0] = watchdog_expired_flag;
            end
            IDX_WATCHDOG_TIMEOUT_INTERVAL: begin
                read_next = watchdog_timeout_count;
            end
            IDX_EVENTS: begin
                read_next[EVT_WDT] = watchdog_event_flag;
                read_next[EVT_MASTER] = irq;
            end
            IDX_INT_ENABLE: begin
                read_next[IE_WDT] = wdt_int_enable_reg;
                read_next[IE_MASTER] = master_int_enable_reg;
            end
            IDX_OUTPUT_NORMAL: begin
                read_next[OUT_W-1:0] = output_normal_reg;
            end
            IDX_OUTPUT_EXPIRE: begin
                read_next[OUT_W-1:0] = output_expire_reg;
            end
            IDX_INPUT_STATE: begin
                read_next[IN_W-1:0] = filtered_in;
            end
            default: begin
                read_next = 32'h0000_0000;
            end
        endcase
    end

    // Read data is captured as waitrequest falls and held until next read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_start) begin
            avs_readdata <= read_next;
        end
    end

    // ------------------------------------------------------------
    // Glitch window register
    // ------------------------------------------------------------
    // Upper bits are not stored; software is expected to keep them zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            glitch_window_count <= RST_GLITCH_WINDOW[GLITCH_W-1:0];
        end else if (wr_go && avs_address == IDX_GLITCH_WINDOW) begin
            if (avs_byteenable[0]) begin
                glitch_window_count[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                glitch_window_count[15:8] <= avs_writedata[15:8];
            end
            if (avs_byteenable[2]) begin
                // Bits 31-20 dropped
                glitch_window_count[19:16] <= avs_writedata[19:16];
            end
        end
    end

    // ------------------------------------------------------------
    // System clock source choice
    // ------------------------------------------------------------
    // Disable bit: only a write sets or clears it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_clock_choice_off <= 1'b0;
        end else if (wr_go && avs_address == IDX_CLOCK_SOURCE_SELECT
                     && avs_byteenable[0]) begin
            auto_clock_choice_off <= avs_writedata[CLK_AUTO_OFF];
        end
    end

    // Source follows the disable bit, else backplane presence
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            system_clock_source_flag <= 1'b0;
            clk_source_onboard <= 1'b0;
        end else begin
            // Forced onboard; else fallback
            system_clock_source_flag <= auto_clock_choice_off
                                        || !backplane_clk_present;
            clk_source_onboard <= auto_clock_choice_off
                                  || !backplane_clk_present;
        end
    end

    // ------------------------------------------------------------
    // Watchdog configuration registers
    // ------------------------------------------------------------
    // Action enable and timeout are plain read-write storage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_expire_action_enable <= 1'b0;
            watchdog_timeout_count <= RST_WDT_TIMEOUT;
        end else if (wr_go) begin
            if (avs_address == IDX_WDT_ACTION_ENABLE
                && avs_byteenable[0]) begin
                watchdog_expire_action_enable <= avs_writedata[0];
            end
            if (avs_address == IDX_WATCHDOG_TIMEOUT_INTERVAL) begin
                for (int b = 0; b < 4; b++) begin
                    if (avs_byteenable[b]) begin
                        watchdog_timeout_count[b*8 +: 8] <=
                            avs_writedata[b*8 +: 8];
                    end
                end
            end
        end
    end

    // Output value registers and interrupt enables
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_normal_reg <= '0;
            output_expire_reg <= '0;
            wdt_int_enable_reg <= 1'b0;
            master_int_enable_reg <= 1'b0;
        end else if (wr_go && avs_byteenable[0]) begin
            if (avs_address == IDX_OUTPUT_NORMAL) begin
                output_normal_reg <= avs_writedata[OUT_W-1:0];
            end
            if (avs_address == IDX_OUTPUT_EXPIRE) begin
                output_expire_reg <= avs_writedata[OUT_W-1:0];
            end
            if (avs_address == IDX_INT_ENABLE) begin
                wdt_int_enable_reg <= avs_writedata[IE_WDT];
                master_int_enable_reg <= avs_writedata[IE_MASTER];
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog timer
    // ------------------------------------------------------------
    localparam logic [3:0] WDT_PRE_LAST = 4'(WDT_TICK_CYCLES - 1);

    assign wdt_tick = (wdt_pre_reg == WDT_PRE_LAST);
    // A zero timeout leaves the watchdog idle
    assign wdt_hit = (watchdog_timeout_count != 32'h0000_0000)
                     && (wdt_ticks_reg >= watchdog_timeout_count)
                     && !watchdog_expired_flag;

    // Prescaler and tick counter restart together so each restart gives
    // the full programmed interval
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_pre_reg <= 4'h0;
            wdt_ticks_reg <= 32'h0000_0000;
        end else if (strobe_restart || strobe_expiry_clear) begin
            wdt_pre_reg <= 4'h0;
            wdt_ticks_reg <= 32'h0000_0000;
        end else if (watchdog_expired_flag) begin
            wdt_pre_reg <= 4'h0;                            // Frozen
        end else if (wdt_tick) begin
            wdt_pre_reg <= 4'h0;
            if (wdt_ticks_reg != 32'hffff_ffff) begin
                wdt_ticks_reg <= wdt_ticks_reg + 32'h0000_0001;
            end
        end else begin
            wdt_pre_reg <= wdt_pre_reg + 4'h1;
        end
    end

    // Expiry state; a hit in the same cycle as a clear wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_expired_flag <= 1'b0;
        end else if (wdt_hit) begin
            watchdog_expired_flag <= 1'b1;
        end else if (strobe_expiry_clear) begin
            watchdog_expired_flag <= 1'b0;
        end
    end

    // Sticky event flag; set wins over software clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_event_flag <= 1'b0;
        end else if (wdt_hit) begin
            watchdog_event_flag <= 1'b1;
        end else if (strobe_event_clear) begin
            watchdog_event_flag <= 1'b0;
        end
    end

    // Interrupt needs the flag and both enables
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= watchdog_event_flag && wdt_int_enable_reg
                   && master_int_enable_reg;
        end
    end

    // ------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------
    // Expiry values only while expired and the action is enabled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= '0;
        end else if (watchdog_expired_flag
                     && watchdog_expire_action_enable) begin
            data_out <= output_expire_reg;
        end else begin
            data_out <= output_normal_reg;
        end
    end

    // ------------------------------------------------------------
    // Input glitch filter
    // ------------------------------------------------------------
    input_glitch_filter #(
        .IN_W(IN_W)
    ) u_filter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .raw_in(raw_in),
        .window_count(glitch_window_count),
        .filtered_out(filtered_in)
    );

endmodule

// ### tb/dio_regs_monitor.sv
// Checker for the register block: read values and clock source flag.
// Sees only the top ports; bound to the block after the module.
`timescale 1ns/1ps
module dio_regs_monitor
    import dio_regs_pkg::*;
#(
    parameter logic [31:0] VERSION_WORD = 32'h0001_0000 // Arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic backplane_clk_present,
    input wire logic clk_source_onboard,
    input wire logic watchdog_expired_flag
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic rd_go; // Read seen while waiting, data due next cycle
    logic wr_done; // Write completes at this edge
    assign rd_go = avs_read && avs_waitrequest;
    assign wr_done = avs_write && !avs_waitrequest;
    a_version_word: assert property (
        rd_go && avs_address == IDX_DEVICE_VERSION
        |=> avs_readdata == VERSION_WORD) else $error("bad version word");
    a_window_upper: assert property (
        rd_go && avs_address == IDX_GLITCH_WINDOW
        |=> avs_readdata[31:20] == 12'h000) else $error("window bits high");
    a_clock_byte: assert property (
        rd_go && avs_address == IDX_CLOCK_SOURCE_SELECT
        |=> avs_readdata[0] == 1'b0 && avs_readdata[31:2] == 30'h0)
        else $error("clock byte reads back write-only bit");
    a_fallback_onboard: assert property (
        !backplane_clk_present |=> clk_source_onboard)
        else $error("no fallback to onboard clock");
    a_backplane_back: assert property (
        $fell(clk_source_onboard) |-> $past(backplane_clk_present))
        else $error("backplane chosen while absent");
    a_expired_holds: assert property (
        watchdog_expired_flag && !wr_done |=> watchdog_expired_flag)
        else $error("expiry dropped without a write");
    a_status_zero: assert property (
        rd_go && avs_address == IDX_WDT_EXPIRED_STATUS
        && !watchdog_expired_flag ##1 !watchdog_expired_flag
        |-> avs_readdata == 32'h0) else $error("status not zero");
    a_status_one: assert property (
        rd_go && avs_address == IDX_WDT_EXPIRED_STATUS
        && watchdog_expired_flag ##1 watchdog_expired_flag
        |-> avs_readdata == 32'h1) else $error("status not one");
endmodule

bind dio_watchdog_filter_clock_regs dio_regs_monitor #(
    .VERSION_WORD(VERSION_WORD)
) u_mon (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .backplane_clk_present(backplane_clk_present),
    .clk_source_onboard(clk_source_onboard),
    .watchdog_expired_flag(watchdog_expired_flag)
);

// ### tb/dio_watchdog_filter_clock_regs_tb_top.sv
// Self-checking bench for the register block, driven over Avalon-MM.
// Assumes one 100 MHz clock; all inputs change by NBA at rising edges.
`timescale 1ns/1ps
module dio_watchdog_filter_clock_regs_tb_top;
    import dio_regs_pkg::*;
    localparam logic [31:0] VER = 32'h0000_00c3; // Arbitrary value
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic bp_present = 1'b1; // Backplane clock present
    logic [7:0] raw_in = 8'h00;
    logic [7:0] filtered_in;
    logic [7:0] data_out;
    logic clk_source_onboard;
    logic watchdog_expired_flag;
    logic irq;
    logic [31:0] rd; // Last read data
    int errors = 0;
    int checks = 0;
    always #5 core_clk = ~core_clk;
    dio_watchdog_filter_clock_regs #(.VERSION_WORD(VER)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .backplane_clk_present(bp_present), .raw_in(raw_in),
        .filtered_in(filtered_in), .data_out(data_out),
        .clk_source_onboard(clk_source_onboard),
        .watchdog_expired_flag(watchdog_expired_flag), .irq(irq));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus cycle, held until waitrequest is seen low; a gap edge after
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            errors++;
            tally_and_finish();
        end
        @(posedge core_clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_chk(IDX_DEVICE_VERSION, VER);
        wr_reg(IDX_DEVICE_VERSION, 32'h0);
        rd_chk(IDX_DEVICE_VERSION, VER);
        rd_chk(IDX_GLITCH_WINDOW, RST_GLITCH_WINDOW);
        wr_reg(IDX_GLITCH_WINDOW, 32'h000f_ffff);
        rd_chk(IDX_GLITCH_WINDOW, 32'h000f_ffff);
        rd_chk(8'h3f, 32'h0);
        wr_reg(IDX_WATCHDOG_TIMEOUT_INTERVAL, 32'hffff_fffe);
        rd_chk(IDX_WATCHDOG_TIMEOUT_INTERVAL, 32'hffff_fffe);
    endtask
    task automatic t_clock();
        rd_chk(IDX_CLOCK_SOURCE_SELECT, 32'h0);
        bp_present <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(clk_source_onboard, 1'b1);
        rd_chk(IDX_CLOCK_SOURCE_SELECT, 32'h2);
        bp_present <= 1'b1;
        wr_reg(IDX_CLOCK_SOURCE_SELECT, 32'h1);
        rd_chk(IDX_CLOCK_SOURCE_SELECT, 32'h2);
        wr_reg(IDX_CLOCK_SOURCE_SELECT, 32'h0);
        rd_chk(IDX_CLOCK_SOURCE_SELECT, 32'h0);
    endtask
    // Window 3 counts is about 60 cycles; a 10-cycle pulse must vanish
    task automatic t_filter();
        wr_reg(IDX_GLITCH_WINDOW, 32'h3);
        raw_in <= 8'h3c;
        repeat (10) @(posedge core_clk);
        raw_in <= 8'h00;
        repeat (80) @(posedge core_clk);
        chk(filtered_in, 8'h00);
        raw_in <= 8'h3c;
        repeat (30) @(posedge core_clk);
        chk(filtered_in, 8'h00);
        repeat (70) @(posedge core_clk);
        chk(filtered_in, 8'h3c);
    endtask
    task automatic t_watchdog();
        int n;
        wr_reg(IDX_OUTPUT_NORMAL, 32'h5a);
        wr_reg(IDX_OUTPUT_EXPIRE, 32'ha5);
        wr_reg(IDX_WDT_ACTION_ENABLE, 32'h1);
        wr_reg(IDX_INT_ENABLE, 32'h24);
        // Counter has run since reset; restart it before arming
        wr_reg(IDX_STROBES, 32'h20);
        wr_reg(IDX_WATCHDOG_TIMEOUT_INTERVAL, 32'h3);
        // Restarts every 18 cycles keep a 30-cycle timeout from firing
        repeat (4) begin
            wr_reg(IDX_STROBES, 32'h20);
            repeat (15) @(posedge core_clk);
            chk(watchdog_expired_flag, 1'b0);
        end
        chk(data_out, 8'h5a);
        wr_reg(IDX_STROBES, 32'h20);
        n = 0;
        while (watchdog_expired_flag !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        chk(n >= 26 && n <= 34, 1'b1);
        if (n >= 100) begin
            tally_and_finish();
        end
        repeat (2) @(posedge core_clk);
        chk(data_out, 8'ha5);
        chk(irq, 1'b1);
        rd_chk(IDX_WDT_EXPIRED_STATUS, 32'h1);
        rd_chk(IDX_EVENTS, 32'h24);
        wr_reg(IDX_INT_ENABLE, 32'h20);
        @(posedge core_clk);
        chk(irq, 1'b0);
        wr_reg(IDX_WATCHDOG_TIMEOUT_INTERVAL, 32'h0);
        wr_reg(IDX_STROBES, 32'h10);
        @(posedge core_clk);
        chk(watchdog_expired_flag, 1'b0);
        chk(data_out, 8'h5a);
        rd_chk(IDX_WDT_EXPIRED_STATUS, 32'h0);
        wr_reg(IDX_STROBES, 32'h40);
        rd_chk(IDX_EVENTS, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_clock();
        t_filter();
        t_watchdog();
        tally_and_finish();
    end
endmodule
